// ===== design/fws_sequencer.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - Starting a program never erases the row on its own.
// - An erase acts on exactly one row.
// - One program writes up to the 32 latch words of a row.
// - Upper ten address bits pick the row, lower five pick the latch.
// - Latch choice and the committed write stay inside one row.
// - After any write or erase every latch returns to blank.
// - Latch loads and programming need an unbroken unlock sequence.
// - With latch-only set, unlock just loads the selected latch.
// - With latch-only clear, unlock loads the final word then programs the row.
module fws_sequencer
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [9:0]  flash_row_o,
  output logic             flash_cfg_o,
  output logic      [4:0]  flash_word_idx_o,
  output logic      [13:0] flash_word_o,
  output logic             flash_word_valid_o,
  output logic             flash_commit_o,
  output logic             flash_erase_o,
  input  wire logic        flash_done_i
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [6:0]               addr_high;
  logic [7:0]               addr_low;
  logic [7:0]               data_low;
  logic [5:0]               data_high;
  logic                     write_enable_bit;
  logic                     config_space_select;
  logic                     latch_only_bit;
  logic                     erase_sel;
  logic                     busy;
  logic [31:0]              loaded;
  fws_pkg::fws_state_t      state;
  fws_pkg::fws_unlock_t     unlock;
  logic [4:0]               rd_idx;
  logic                     rd_stop;
  logic                     rd_pend;
  logic [4:0]               idx_d;
  logic                     loaded_d;
  logic [13:0]              mem_rdata;

  function automatic logic hit(input logic [2:0] off);
    hit = reg_wr_i && (reg_addr_i == off);
  endfunction

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  logic go;
  logic act;
  logic load_now;
  logic rd_en;
  logic [4:0] latch_idx;
  logic [13:0] data_word;

  assign go        = (unlock == fws_pkg::UL_KEY2) && hit(fws_pkg::OFF_CONTROL) && reg_wdata_i[fws_pkg::CTRL_START];
  assign act       = go && reg_wdata_i[fws_pkg::CTRL_WRITE_ENABLE_BIT] && (state == fws_pkg::ST_IDLE);
  assign load_now  = act && !reg_wdata_i[fws_pkg::CTRL_ERASE];
  assign latch_idx = addr_low[4:0];
  assign data_word = {data_high, data_low};
  assign rd_en     = (state == fws_pkg::ST_STREAM) && !rd_stop;

  // Any other write between the steps breaks the sequence; reads leave it alone.
  // interrupted sequence
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      unlock <= fws_pkg::UL_NONE;
    end
    else if (reg_wr_i)
    begin
      if (hit(fws_pkg::OFF_UNLOCK) && reg_wdata_i == fws_pkg::UNLOCK_KEY1)
      begin
        unlock <= fws_pkg::UL_KEY1;
      end
      else if (unlock == fws_pkg::UL_KEY1 && hit(fws_pkg::OFF_UNLOCK) && reg_wdata_i == fws_pkg::UNLOCK_KEY2)
      begin
        unlock <= fws_pkg::UL_KEY2;
      end
      else
      begin
        unlock <= fws_pkg::UL_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_high <= 7'h00;
      addr_low  <= fws_pkg::RST_BYTE;
      data_low  <= fws_pkg::RST_BYTE;
      data_high <= 6'h00;
      write_enable_bit      <= 1'b0;
      config_space_select      <= 1'b0;
      latch_only_bit      <= 1'b0;
      erase_sel <= 1'b0;
    end
    else
    begin
      if (hit(fws_pkg::OFF_ADDR_LOW))
        addr_low <= reg_wdata_i;
      if (hit(fws_pkg::OFF_ADDR_HIGH))
        addr_high <= reg_wdata_i[6:0];
      if (hit(fws_pkg::OFF_DATA_LOW))
        data_low <= reg_wdata_i;
      if (hit(fws_pkg::OFF_DATA_HIGH))
        data_high <= reg_wdata_i[5:0];
      if (hit(fws_pkg::OFF_CONTROL))
      begin
        write_enable_bit      <= reg_wdata_i[fws_pkg::CTRL_WRITE_ENABLE_BIT];
        config_space_select      <= reg_wdata_i[fws_pkg::CTRL_CONFIG_SPACE_SELECT];
        latch_only_bit      <= reg_wdata_i[fws_pkg::CTRL_LATCH_ONLY_BIT];
        erase_sel <= reg_wdata_i[fws_pkg::CTRL_ERASE];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= fws_pkg::RST_BYTE;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        fws_pkg::OFF_ADDR_LOW:  reg_rdata_o <= addr_low;
        fws_pkg::OFF_ADDR_HIGH: reg_rdata_o <= {1'b0, addr_high};
        fws_pkg::OFF_DATA_LOW:  reg_rdata_o <= data_low;
        fws_pkg::OFF_DATA_HIGH: reg_rdata_o <= {2'b00, data_high};
        fws_pkg::OFF_CONTROL:   reg_rdata_o <= {1'b0, config_space_select, latch_only_bit, 2'b00, write_enable_bit, erase_sel, busy};
        default:                reg_rdata_o <= fws_pkg::RST_BYTE;
      endcase
    end
    else
    begin
      reg_rdata_o <= fws_pkg::RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Write latches
  // ----------------------------------------------------------------
  // latch load, latch-only or final word
  fws_latch_mem u_latch_mem
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .wr_en_i    (load_now),
    .wr_idx_i   (latch_idx),
    .wr_data_i  (data_word),
    .rd_en_i    (rd_en),
    .rd_idx_i   (rd_idx),
    .rd_data_o  (mem_rdata)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      loaded <= 32'h0000_0000;
    end
    else if (state == fws_pkg::ST_WAIT && flash_done_i)
    begin
      loaded <= 32'h0000_0000;
    end
    else if (load_now)
    begin
      loaded[latch_idx] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Program and erase sequence
  // ----------------------------------------------------------------
  // no implicit erase
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state         <= fws_pkg::ST_IDLE;
      busy          <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_row_o   <= 10'h000;
      flash_cfg_o   <= 1'b0;
    end
    else
    begin
      flash_erase_o <= 1'b0;
      unique case (state)
        fws_pkg::ST_IDLE:
        begin
          if (act && !reg_wdata_i[fws_pkg::CTRL_LATCH_ONLY_BIT])
          begin
            busy          <= 1'b1;
            flash_row_o   <= {addr_high, addr_low[7:5]};
            flash_cfg_o   <= reg_wdata_i[fws_pkg::CTRL_CONFIG_SPACE_SELECT];
            flash_erase_o <= reg_wdata_i[fws_pkg::CTRL_ERASE];
            state         <= reg_wdata_i[fws_pkg::CTRL_ERASE] ? fws_pkg::ST_WAIT : fws_pkg::ST_STREAM;
          end
        end
        fws_pkg::ST_STREAM:
        begin
          if (rd_pend && idx_d == fws_pkg::LAST_IDX)
            state <= fws_pkg::ST_WAIT;
        end
        fws_pkg::ST_WAIT:
        begin
          if (flash_done_i)
          begin
            busy  <= 1'b0;
            state <= fws_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // The whole row is streamed on every program; a latch never loaded goes out as the blank word.
  // thirty-two words
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_idx   <= 5'h00;
      rd_stop  <= 1'b0;
      rd_pend  <= 1'b0;
      idx_d    <= 5'h00;
      loaded_d <= 1'b0;
    end
    else
    begin
      rd_pend  <= rd_en;
      idx_d    <= rd_idx;
      loaded_d <= loaded[rd_idx];
      if (state == fws_pkg::ST_IDLE)
      begin
        rd_idx  <= 5'h00;
        rd_stop <= 1'b0;
      end
      else if (rd_en)
      begin
        rd_stop <= (rd_idx == fws_pkg::LAST_IDX);
        rd_idx  <= rd_idx + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flash_word_o       <= 14'h0000;
      flash_word_idx_o   <= 5'h00;
      flash_word_valid_o <= 1'b0;
      flash_commit_o     <= 1'b0;
    end
    else
    begin
      flash_word_valid_o <= rd_pend;
      flash_commit_o     <= rd_pend && (idx_d == fws_pkg::LAST_IDX);
      if (rd_pend)
      begin
        flash_word_idx_o <= idx_d;
        flash_word_o     <= loaded_d ? mem_rdata : fws_pkg::BLANK_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] word_cnt;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      word_cnt <= 6'h00;
    else if (flash_commit_o)
      word_cnt <= 6'h00;
    else if (flash_word_valid_o)
      word_cnt <= word_cnt + 6'h01;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_no_auto_erase: assert property (flash_word_valid_o || flash_commit_o |-> !flash_erase_o)
    else $error("erase seen during a program");
  chk_erase_single: assert property (flash_erase_o |=> !flash_erase_o && state == fws_pkg::ST_WAIT)
    else $error("erase pulse not single");
  chk_word_count: assert property (flash_commit_o |-> word_cnt == 6'd31 && flash_word_idx_o == 5'd31)
    else $error("commit not after 32 words");
  chk_latch_select: assert property (load_now |=> loaded[$past(addr_low[4:0])])
    else $error("wrong latch marked loaded");
  chk_row_stable: assert property (flash_word_valid_o && $past(flash_word_valid_o) |-> $stable(flash_row_o))
    else $error("row changed inside a program");
  chk_blank_reset: assert property (state == fws_pkg::ST_WAIT && flash_done_i |=> loaded == 32'h0)
    else $error("latches not blank after completion");
  chk_unlock_need: assert property ($rose(busy) |-> $past(unlock) == fws_pkg::UL_KEY2)
    else $error("operation started without unlock");
  chk_latch_only: assert property (act && reg_wdata_i[fws_pkg::CTRL_LATCH_ONLY_BIT] |=> state == fws_pkg::ST_IDLE [*3])
    else $error("latch-only unlock started a write");
  chk_commit_go: assert property (load_now && !reg_wdata_i[fws_pkg::CTRL_LATCH_ONLY_BIT] |=> ##[1:40] flash_commit_o)
    else $error("final unlock did not commit");
  chk_write_enable_bit_gate: assert property (go && !reg_wdata_i[fws_pkg::CTRL_WRITE_ENABLE_BIT] && !busy |=> !busy && !loaded_d[*1])
    else $error("unlock acted while write disabled");
  chk_blank_word: assert property (rd_pend && !loaded_d |=> flash_word_o == 14'h3FFF)
    else $error("unloaded latch not blank");

  cov_latch_load: cover property (load_now && latch_only_bit);
  cov_row_commit: cover property (flash_commit_o);
  cov_row_erase: cover property (flash_erase_o);
  cov_broken_unlock: cover property (unlock == fws_pkg::UL_KEY1 ##1 unlock == fws_pkg::UL_NONE);

endmodule

// ===== design/fws_pkg.sv
package fws_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 3;
  localparam int REG_DATA_W = 8;
  localparam int WORD_W     = 14;
  localparam int NUM_LATCH  = 32;
  localparam int IDX_W      = 5;
  localparam int ROW_W      = 10;
  localparam int ADDR_HI_W  = 7;
  localparam int DATA_HI_W  = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_ADDR_LOW  = 3'h0;
  localparam logic [2:0] OFF_ADDR_HIGH = 3'h1;
  localparam logic [2:0] OFF_DATA_LOW  = 3'h2;
  localparam logic [2:0] OFF_DATA_HIGH = 3'h3;
  localparam logic [2:0] OFF_CONTROL   = 3'h4;
  localparam logic [2:0] OFF_UNLOCK    = 3'h5;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_WRITE_ENABLE_BIT  = 2;
  localparam int CTRL_LATCH_ONLY_BIT  = 5;
  localparam int CTRL_CONFIG_SPACE_SELECT  = 6;

  // ----------------------------------------------------------------
  // Address fields
  // ----------------------------------------------------------------
  localparam int IDX_LSB = 0;
  localparam int ROW_LO_LSB = 5;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0]        UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0]        UNLOCK_KEY2 = 8'hAA;
  localparam logic [WORD_W-1:0] BLANK_WORD  = 14'h3FFF;
  localparam logic [IDX_W-1:0]  LAST_IDX    = 5'h1F;
  localparam logic [7:0]        RST_BYTE    = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} fws_state_t;
  typedef enum logic [1:0] {UL_NONE, UL_KEY1, UL_KEY2} fws_unlock_t;

endpackage

// ===== design/fws_latch_mem.sv
`timescale 1ns/1ns
module fws_latch_mem
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_idx_i,
  input  wire logic [13:0] wr_data_i,
  input  wire logic        rd_en_i,
  input  wire logic [4:0]  rd_idx_i,
  output logic      [13:0] rd_data_o
);

  // The array itself needs no reset: a separate loaded mask decides whether a word is blank.
  logic [13:0] mem [0:31];

  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= 14'h0000;
    end
    else if (rd_en_i)
    begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule

// ===== test/fws_flash_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Flash array stand-in
// ----------------------------------------------------------------
// Answers each row program or row erase with a done pulse after a fixed delay.
// Done is a single-cycle pulse, so a sequencer that misses it will hang visibly.
module fws_flash_model
#(
  parameter int DONE_DLY = 5
)
(
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic flash_commit_i,
  input  wire logic flash_erase_i,
  output logic      flash_done_o
);
  int cnt;

  // program or single row erase, then done
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt          <= 0;
      flash_done_o <= 1'b0;
    end
    else
    begin
      flash_done_o <= 1'b0;
      if (flash_commit_i || flash_erase_i)
        cnt <= DONE_DLY;
      else if (cnt == 1)
      begin
        cnt          <= 0;
        flash_done_o <= 1'b1;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule

// ===== test/flash_row_write_sequencer_bench.sv
`timescale 1ns/1ns
module flash_row_write_sequencer_bench;
  typedef struct {logic [4:0] idx; logic [13:0] d;} fws_row_t;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        reg_wr_i   = 1'b0;
  logic        reg_rd_i   = 1'b0;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o, v;
  logic [9:0]  flash_row_o, crow;
  logic [4:0]  flash_word_idx_o, cidx;
  logic [13:0] flash_word_o;
  logic        flash_cfg_o, flash_word_valid_o, flash_commit_o, flash_erase_o, flash_done_i;
  logic [13:0] cap [32];
  logic [13:0] exp_w [32];
  int          num_errors = 0;
  int          n_tests    = 0;
  int          nwords, ncommit, nerase;
  fws_row_t    tbl [4] = '{'{5'h00, 14'h0123}, '{5'h01, 14'h3ABC}, '{5'h0F, 14'h2000}, '{5'h1E, 14'h0001}};

  fws_sequencer u_fws_sequencer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .flash_row_o(flash_row_o), .flash_cfg_o(flash_cfg_o), .flash_word_idx_o(flash_word_idx_o),
    .flash_word_o(flash_word_o), .flash_word_valid_o(flash_word_valid_o), .flash_commit_o(flash_commit_o),
    .flash_erase_o(flash_erase_o), .flash_done_i(flash_done_i));
  fws_flash_model u_fws_flash_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .flash_commit_i(flash_commit_o), .flash_erase_i(flash_erase_o), .flash_done_o(flash_done_i));

  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Array-side monitor
  // ----------------------------------------------------------------
  // Sampled on the falling edge so registered outputs are settled.
  always @(negedge core_clk_i)
  begin
    if (flash_word_valid_o === 1'b1)
    begin
      cap[flash_word_idx_o] = flash_word_o;
      nwords++;
    end
    if (flash_commit_o === 1'b1)
    begin
      ncommit++;
      cidx = flash_word_idx_o;
      crow = flash_row_o;
    end
    if (flash_erase_o === 1'b1)
    begin
      nerase++;
      crow = flash_row_o;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Writes stay back to back; idle drops the strobe afterwards.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
  endtask

  task automatic idle;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge core_clk_i);
    reg_wr_i   <= 1'b0;
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask

  task automatic unlock(input logic [7:0] c);
    wr(fws_pkg::OFF_UNLOCK, fws_pkg::UNLOCK_KEY1);
    wr(fws_pkg::OFF_UNLOCK, fws_pkg::UNLOCK_KEY2);
    wr(fws_pkg::OFF_CONTROL, c);
    idle;
  endtask

  task automatic setup(input logic [9:0] r, input logic [4:0] i, input logic [13:0] d);
    wr(fws_pkg::OFF_ADDR_LOW, {r[2:0], i});
    wr(fws_pkg::OFF_ADDR_HIGH, {1'b0, r[9:3]});
    wr(fws_pkg::OFF_DATA_LOW, d[7:0]);
    wr(fws_pkg::OFF_DATA_HIGH, {2'b00, d[13:8]});
  endtask

  task automatic clr_exp;
    foreach (exp_w[i]) exp_w[i] = fws_pkg::BLANK_WORD;
    nwords  = 0;
    ncommit = 0;
    nerase  = 0;
  endtask

  task automatic wait_idle;
    v = 8'h01;
    for (int k = 0; k < 100 && v[0] !== 1'b0; k++) rd(fws_pkg::OFF_CONTROL, v);
    check(v[0], 1'b0);
  endtask

  task automatic check_prog(input logic [9:0] r, input logic c);
    check(nwords, 32);
    check(ncommit, 1);
    check(cidx, 5'h1F);
    check(nerase, 0);
    check(crow, r);
    check(flash_cfg_o, c);
    foreach (cap[i]) check(cap[i], exp_w[i]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(fws_pkg::OFF_CONTROL, v);
    check(v, 8'h00);
    check({flash_word_valid_o, flash_commit_o, flash_erase_o}, 3'h0);
    rd(3'h6, v);
    check(v, 8'h00);
    clr_exp;
    // latch loads with write enable and latch-only set
    foreach (tbl[i])
    begin
      setup(10'h2A5, tbl[i].idx, tbl[i].d);
      unlock(8'h25);
      exp_w[tbl[i].idx] = tbl[i].d;
    end
    check(nwords, 0);
    rd(fws_pkg::OFF_CONTROL, v);
    check(v, 8'h24);
    rd(fws_pkg::OFF_ADDR_LOW, v);
    check(v, 8'hBE);
    rd(fws_pkg::OFF_ADDR_HIGH, v);
    check(v, 8'h54);
    // final word with latch-only clear commits
    setup(10'h2A5, 5'h1F, 14'h1555);
    unlock(8'h05);
    exp_w[31] = 14'h1555;
    wait_idle;
    check_prog(10'h2A5, 1'b0);
    // Latches left blank by the previous write; only the final word is loaded.
    clr_exp;
    setup(10'h001, 5'h1F, 14'h0000);
    unlock(8'h45);
    exp_w[31] = 14'h0000;
    wait_idle;
    check_prog(10'h001, 1'b1);
    clr_exp;
    setup(10'h3FF, 5'h05, 14'h0AAA);
    wr(fws_pkg::OFF_UNLOCK, fws_pkg::UNLOCK_KEY1);
    wr(fws_pkg::OFF_DATA_LOW, 8'h11);
    wr(fws_pkg::OFF_UNLOCK, fws_pkg::UNLOCK_KEY2);
    wr(fws_pkg::OFF_CONTROL, 8'h25);
    idle;
    setup(10'h3FF, 5'h06, 14'h0111);
    unlock(8'h21);
    unlock(8'h01);
    repeat (40) @(posedge core_clk_i);
    check(nwords, 0);
    setup(10'h3FF, 5'h07, 14'h0222);
    unlock(8'h25);
    unlock(8'h07);
    wait_idle;
    check(nerase, 1);
    check(crow, 10'h3FF);
    check(nwords, 0);
    clr_exp;
    // row is programmed only after its erase
    setup(10'h3FF, 5'h1F, 14'h3000);
    unlock(8'h05);
    exp_w[31] = 14'h3000;
    wait_idle;
    check_prog(10'h3FF, 1'b0);
    end_of_test;
  end

  initial
  begin
    #(8 * 20000);
    num_errors++;
    end_of_test;
  end
endmodule
